/* verilog/flsb_consts.svh */
`ifndef FLSB_CONSTS_SVH
`define FLSB_CONSTS_SVH

// Command codes
`define FLSB_CMD_CLEAR      8'h03
`define FLSB_CMD_OUV_ACT    8'h45
`define FLSB_CMD_OC_TRIP    8'h46
`define FLSB_CMD_OC_ACT     8'h47
`define FLSB_CMD_OLV_TRIP   8'h48
`define FLSB_CMD_OC_WARN    8'h4a
`define FLSB_CMD_OT_TRIP    8'h4f
`define FLSB_CMD_OT_ACT     8'h50
`define FLSB_CMD_OT_WARN    8'h51
`define FLSB_CMD_VOV_TRIP   8'h55
`define FLSB_CMD_VOV_ACT    8'h56
`define FLSB_CMD_VUV_WARN   8'h58
`define FLSB_CMD_VUV_TRIP   8'h59
`define FLSB_CMD_VUV_ACT    8'h5a
`define FLSB_CMD_SUM_BYTE   8'h78
`define FLSB_CMD_SUM_WORD   8'h79
`define FLSB_CMD_VOUT_FLG   8'h7a
`define FLSB_CMD_IOUT_FLG   8'h7b
`define FLSB_CMD_IN_FLG     8'h7c
`define FLSB_CMD_TEMP_FLG   8'h7d
`define FLSB_CMD_COMM_FLG   8'h7e

// Fault action codes
`define FLSB_CODE_80        8'h80
`define FLSB_CODE_C0        8'hc0
`define FLSB_CODE_F8        8'hf8

// Reset values, thresholds in whole volts, amperes or degrees
`define FLSB_RST_OUV_ACT    8'hc0
`define FLSB_RST_OC_ACT     8'hf8
`define FLSB_RST_OT_ACT     8'hc0
`define FLSB_RST_VOV_ACT    8'hc0
`define FLSB_RST_VUV_ACT    8'hc0
`define FLSB_RST_OC_TRIP    16'h0040
`define FLSB_RST_OLV_TRIP   16'h0024
`define FLSB_RST_OC_WARN    16'h003c
`define FLSB_RST_OT_TRIP    16'h0064
`define FLSB_RST_OT_WARN    16'h005a
`define FLSB_RST_VOV_TRIP   16'h012c
`define FLSB_RST_VUV_WARN   16'h005a
`define FLSB_RST_VUV_TRIP   16'h0055
`define FLSB_LOWLINE_OC     16'h001e
`define FLSB_LOWLINE_WARN   16'h001d

// Communication flag bit positions
`define FLSB_COMM_BAD_CMD   7
`define FLSB_COMM_BAD_DATA  6
`define FLSB_COMM_PEC       5
`define FLSB_COMM_OTHER     1

`endif

/* verilog/flsb_pkg.sv */
package flsb_pkg;

  typedef struct packed {
    logic        we;
    logic        pec_bad;
    logic        overrun;
    logic [7:0]  code;
    logic [15:0] wdata;
  } flsb_req_s;

  typedef struct packed {
    logic [15:0] vout;
    logic [15:0] iout;
    logic [15:0] vin;
    logic [15:0] temp;
  } flsb_meas_s;

  typedef struct packed {
    logic busy;
    logic high_line;
    logic input_interrupt;
    logic vout_uv_detect;
    logic vout_ov_fault;
    logic vout_ov_warn;
    logic vout_uv_warn;
    logic vin_ov_warn;
    logic iin_oc_fault;
    logic share_fault;
    logic power_limit;
    logic pgood_n;
  } flsb_cond_s;

  typedef enum logic {LNK_IDLE, LNK_WAIT} flsb_lnk_e;

endpackage

/* verilog/flsb_bank.sv */
// How it works
// RULE1 - Output undervoltage action accepts 0x80 latch or 0xC0 restart, resets to restart.
// RULE2 - Overcurrent trip register applies at high line; low line uses fixed 30 A.
// RULE3 - Overcurrent action resets to hiccup 0xF8, accepts 0xC0 latch, any line.
// RULE4 - In overload, shut down below low-voltage level unless input was interrupted.
// RULE5 - Current warning register applies at high line; low line warns at 29 A.
// RULE6 - Secondary-side temperature above trip level runs the overtemperature action.
// RULE7 - Overtemperature action resets to hiccup 0xC0, accepts 0x80 latch.
// RULE8 - Temperature above warning level flags an overtemperature warning.
// RULE9 - Input above overvoltage level shuts down; level may only be lowered.
// RULE10 - Input overvoltage action resets to restart 0xC0, accepts 0x80 latch.
// RULE11 - Input below warning level warns; level may only be raised.
// RULE12 - Input below undervoltage level shuts down; default 85, may be raised.
// RULE13 - Input undervoltage action resets to restart 0xC0, accepts 0x80 latch.
// RULE14 - Summary byte: busy, off, vout OV, iout OC, vin UV, temp, comm, other.
// RULE15 - Status word: summary byte low, category summaries in the high byte.
// RULE16 - Output voltage flags: OV fault, OV warn, UV warn, UV fault in bits 7..4.
// RULE17 - Output current flags: OC, low-voltage, warning, share fault, power limiting.
// RULE18 - Overcurrent limits current; shutdown only on low voltage during overload.
// RULE19 - Input flags: OV fault, OV warn, UV warn, UV fault, off low, input OC.
// RULE20 - Temperature flags: fault in bit 7, warning in bit 6, rest zero.
// RULE21 - Comm flags: bad command, bad data, packet check failed, other fault.
// RULE22 - Successful restart clears every status register to zero.
// RULE23 - Illegal fault action code is refused and flags invalid data.
// RULE24 - Status bits stick until a restart or a clear command.
`timescale 1ns/1ns
`include "flsb_consts.svh"

module flsb_bank
  import flsb_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire flsb_meas_s  meas,
  input  wire flsb_cond_s  cond,
  input  wire logic        restart,
  output logic             shutdown,
  output logic             latched_off,
  output logic             current_limit,
  input  wire logic        lnk_clk,
  input  wire logic        lnk_req,
  input  wire logic        lnk_we,
  input  wire logic [7:0]  lnk_code,
  input  wire logic [15:0] lnk_wdata,
  input  wire logic        lnk_pec_bad,
  output logic             lnk_busy,
  output logic             lnk_ack,
  output logic [15:0]      lnk_rdata
);

  // ---------------- Link domain ----------------
  logic [1:0]  lnk_rst_sync;
  logic        lnk_rst_b;
  flsb_lnk_e   lnk_state;
  flsb_req_s   lnk_hold;
  logic        req_tgl;
  logic        overrun_pend;
  logic        ack_s1;
  logic        ack_s2;
  logic        ack_s3;
  logic [15:0] rsp_data;
  logic        ack_tgl;

  assign lnk_rst_b = lnk_rst_sync[1];

  always_ff @(posedge lnk_clk) begin
    lnk_rst_sync <= {lnk_rst_sync[0], rst_b};
  end

  always_ff @(posedge lnk_clk) begin
    ack_s1 <= ack_tgl;
    ack_s2 <= ack_s1;
    ack_s3 <= ack_s2;
  end

  always_ff @(posedge lnk_clk) begin
    if (!lnk_rst_b) begin
      lnk_state    <= LNK_IDLE;
      lnk_hold     <= '0;
      req_tgl      <= 1'b0;
      overrun_pend <= 1'b0;
      lnk_busy     <= 1'b0;
      lnk_ack      <= 1'b0;
      lnk_rdata    <= 16'h0000;
    end else begin
      lnk_ack <= 1'b0;
      case (lnk_state)
        LNK_IDLE: begin
          if (lnk_req) begin
            lnk_hold     <= '{we: lnk_we, pec_bad: lnk_pec_bad, overrun: overrun_pend,
                              code: lnk_code, wdata: lnk_wdata};
            overrun_pend <= 1'b0;
            req_tgl      <= ~req_tgl;
            lnk_busy     <= 1'b1;
            lnk_state    <= LNK_WAIT;
          end
        end
        LNK_WAIT: begin
          // A request while busy is dropped and reported with the next one
          if (lnk_req) begin
            overrun_pend <= 1'b1;
          end
          if (ack_s2 != ack_s3) begin
            lnk_rdata <= rsp_data;
            lnk_ack   <= 1'b1;
            lnk_busy  <= 1'b0;
            lnk_state <= LNK_IDLE;
          end
        end
        default: begin
          lnk_state <= LNK_IDLE;
        end
      endcase
    end
  end

  // ---------------- Core domain ----------------
  logic        req_s1;
  logic        req_s2;
  logic        req_s3;
  logic        req_new;

  logic [7:0]  ouv_act;
  logic [7:0]  oc_act;
  logic [7:0]  ot_act;
  logic [7:0]  vov_act;
  logic [7:0]  vuv_act;
  logic [15:0] oc_trip;
  logic [15:0] olv_trip;
  logic [15:0] oc_warn;
  logic [15:0] ot_trip;
  logic [15:0] ot_warn;
  logic [15:0] vov_trip;
  logic [15:0] vuv_warn;
  logic [15:0] vuv_trip;

  logic [7:0]  vout_flg;
  logic [7:0]  iout_flg;
  logic [7:0]  in_flg;
  logic [7:0]  temp_flg;
  logic [7:0]  comm_flg;

  // Hold is stable while the toggle is in flight, so it may be read here
  always_ff @(posedge clk) begin
    req_s1 <= req_tgl;
    req_s2 <= req_s1;
    req_s3 <= req_s2;
  end

  assign req_new = req_s2 != req_s3;

  function automatic logic act_ok(input logic [7:0] code, input logic [7:0] a,
                                  input logic [7:0] b);
    act_ok = (code == a) || (code == b);
  endfunction

  logic [15:0] oc_lim;
  logic [15:0] ocw_lim;
  logic        overload;
  logic        ouv_cond;
  logic        olv_cond;
  logic        ocw_cond;
  logic        ot_cond;
  logic        otw_cond;
  logic        vov_cond;
  logic        vuv_cond;
  logic        vuvw_cond;

  assign oc_lim    = cond.high_line ? oc_trip : `FLSB_LOWLINE_OC;            // RULE2
  assign ocw_lim   = cond.high_line ? oc_warn : `FLSB_LOWLINE_WARN;          // RULE5
  assign overload  = meas.iout >= oc_lim;                                    // RULE18
  assign ouv_cond  = cond.vout_uv_detect && !overload && !cond.input_interrupt;
  assign olv_cond  = overload && (meas.vout < olv_trip) && !cond.input_interrupt; // RULE4
  assign ocw_cond  = meas.iout > ocw_lim;                                    // RULE5
  assign ot_cond   = meas.temp > ot_trip;                                    // RULE6
  assign otw_cond  = meas.temp > ot_warn;                                    // RULE8
  assign vov_cond  = meas.vin > vov_trip;                                    // RULE9
  assign vuv_cond  = meas.vin < vuv_trip;                                    // RULE12
  assign vuvw_cond = meas.vin < vuv_warn;                                    // RULE11

  // Latched trips need a restart; restart and hiccup codes follow the condition
  logic trip_latch;
  logic trip_auto;
  logic next_latched;

  assign trip_latch = (ouv_cond && ouv_act == `FLSB_CODE_80)                 // RULE1
                   || (olv_cond && oc_act  == `FLSB_CODE_C0)                 // RULE3
                   || (ot_cond  && ot_act  == `FLSB_CODE_80)                 // RULE7
                   || (vov_cond && vov_act == `FLSB_CODE_80)                 // RULE10
                   || (vuv_cond && vuv_act == `FLSB_CODE_80);                // RULE13
  assign trip_auto  = ouv_cond || olv_cond || ot_cond || vov_cond || vuv_cond;
  assign next_latched = trip_latch || (latched_off && !restart);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      latched_off   <= 1'b0;
      shutdown      <= 1'b0;
      current_limit <= 1'b0;
    end else begin
      latched_off   <= next_latched;
      shutdown      <= next_latched || trip_auto;
      current_limit <= overload;                                             // RULE18
    end
  end

  // Register writes
  logic        wr_en;
  logic        bad_data;
  logic        bad_cmd;
  logic        clear_cmd;
  logic [15:0] wd;

  assign wr_en = req_new && lnk_hold.we && !lnk_hold.pec_bad;
  assign wd    = lnk_hold.wdata;

  always_comb begin
    bad_data  = 1'b0;
    bad_cmd   = 1'b0;
    clear_cmd = 1'b0;
    if (wr_en) begin
      case (lnk_hold.code)
        `FLSB_CMD_CLEAR:    clear_cmd = 1'b1;
        `FLSB_CMD_OUV_ACT:  bad_data = !act_ok(wd[7:0], `FLSB_CODE_80, `FLSB_CODE_C0); // RULE23
        `FLSB_CMD_OC_ACT:   bad_data = !act_ok(wd[7:0], `FLSB_CODE_F8, `FLSB_CODE_C0); // RULE23
        `FLSB_CMD_OT_ACT:   bad_data = !act_ok(wd[7:0], `FLSB_CODE_80, `FLSB_CODE_C0); // RULE23
        `FLSB_CMD_VOV_ACT:  bad_data = !act_ok(wd[7:0], `FLSB_CODE_80, `FLSB_CODE_C0); // RULE23
        `FLSB_CMD_VUV_ACT:  bad_data = !act_ok(wd[7:0], `FLSB_CODE_80, `FLSB_CODE_C0); // RULE23
        `FLSB_CMD_VOV_TRIP: bad_data = wd > `FLSB_RST_VOV_TRIP;              // RULE9
        `FLSB_CMD_VUV_WARN: bad_data = wd < `FLSB_RST_VUV_WARN;              // RULE11
        `FLSB_CMD_VUV_TRIP: bad_data = wd < `FLSB_RST_VUV_TRIP;              // RULE12
        `FLSB_CMD_OC_TRIP, `FLSB_CMD_OLV_TRIP, `FLSB_CMD_OC_WARN,
        `FLSB_CMD_OT_TRIP, `FLSB_CMD_OT_WARN: bad_data = 1'b0;
        default:            bad_cmd = 1'b1;
      endcase
    end else if (req_new && !lnk_hold.pec_bad) begin
      case (lnk_hold.code)
        `FLSB_CMD_OUV_ACT, `FLSB_CMD_OC_TRIP, `FLSB_CMD_OC_ACT, `FLSB_CMD_OLV_TRIP,
        `FLSB_CMD_OC_WARN, `FLSB_CMD_OT_TRIP, `FLSB_CMD_OT_ACT, `FLSB_CMD_OT_WARN,
        `FLSB_CMD_VOV_TRIP, `FLSB_CMD_VOV_ACT, `FLSB_CMD_VUV_WARN, `FLSB_CMD_VUV_TRIP,
        `FLSB_CMD_VUV_ACT, `FLSB_CMD_SUM_BYTE, `FLSB_CMD_SUM_WORD, `FLSB_CMD_VOUT_FLG,
        `FLSB_CMD_IOUT_FLG, `FLSB_CMD_IN_FLG, `FLSB_CMD_TEMP_FLG,
        `FLSB_CMD_COMM_FLG: bad_cmd = 1'b0;
        default:            bad_cmd = 1'b1;
      endcase
    end
  end

  logic wr_ok;
  assign wr_ok = wr_en && !bad_data && !bad_cmd;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ouv_act  <= `FLSB_RST_OUV_ACT;                                         // RULE1
      oc_act   <= `FLSB_RST_OC_ACT;                                          // RULE3
      ot_act   <= `FLSB_RST_OT_ACT;                                          // RULE7
      vov_act  <= `FLSB_RST_VOV_ACT;                                         // RULE10
      vuv_act  <= `FLSB_RST_VUV_ACT;                                         // RULE13
      oc_trip  <= `FLSB_RST_OC_TRIP;
      olv_trip <= `FLSB_RST_OLV_TRIP;
      oc_warn  <= `FLSB_RST_OC_WARN;
      ot_trip  <= `FLSB_RST_OT_TRIP;
      ot_warn  <= `FLSB_RST_OT_WARN;
      vov_trip <= `FLSB_RST_VOV_TRIP;
      vuv_warn <= `FLSB_RST_VUV_WARN;
      vuv_trip <= `FLSB_RST_VUV_TRIP;
    end else if (wr_ok) begin
      case (lnk_hold.code)
        `FLSB_CMD_OUV_ACT:  ouv_act  <= wd[7:0];
        `FLSB_CMD_OC_ACT:   oc_act   <= wd[7:0];
        `FLSB_CMD_OT_ACT:   ot_act   <= wd[7:0];
        `FLSB_CMD_VOV_ACT:  vov_act  <= wd[7:0];
        `FLSB_CMD_VUV_ACT:  vuv_act  <= wd[7:0];
        `FLSB_CMD_OC_TRIP:  oc_trip  <= wd;
        `FLSB_CMD_OLV_TRIP: olv_trip <= wd;
        `FLSB_CMD_OC_WARN:  oc_warn  <= wd;
        `FLSB_CMD_OT_TRIP:  ot_trip  <= wd;
        `FLSB_CMD_OT_WARN:  ot_warn  <= wd;
        `FLSB_CMD_VOV_TRIP: vov_trip <= wd;
        `FLSB_CMD_VUV_WARN: vuv_warn <= wd;
        `FLSB_CMD_VUV_TRIP: vuv_trip <= wd;
        default: begin
        end
      endcase
    end
  end

  // Sticky status; a new event in the clearing cycle still lands
  logic       flg_clear;
  logic [7:0] comm_set;

  assign flg_clear = restart || clear_cmd;                                   // RULE22

  always_comb begin
    comm_set = 8'h00;
    comm_set[`FLSB_COMM_BAD_CMD]  = bad_cmd;                                 // RULE21
    comm_set[`FLSB_COMM_BAD_DATA] = bad_data;                                // RULE23
    comm_set[`FLSB_COMM_PEC]      = req_new && lnk_hold.pec_bad;
    comm_set[`FLSB_COMM_OTHER]    = req_new && lnk_hold.overrun;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      vout_flg <= 8'h00;
      iout_flg <= 8'h00;
      in_flg   <= 8'h00;
      temp_flg <= 8'h00;
      comm_flg <= 8'h00;
    end else begin
      vout_flg <= (flg_clear ? 8'h00 : vout_flg)                             // RULE24
                | {cond.vout_ov_fault, cond.vout_ov_warn, cond.vout_uv_warn, // RULE16
                   ouv_cond, 4'h0};
      iout_flg <= (flg_clear ? 8'h00 : iout_flg)
                | {overload, olv_cond, ocw_cond, 1'b0,                       // RULE17
                   cond.share_fault, cond.power_limit, 2'h0};
      in_flg   <= (flg_clear ? 8'h00 : in_flg)
                | {vov_cond, cond.vin_ov_warn, vuvw_cond, vuv_cond,          // RULE19
                   vuv_cond, cond.iin_oc_fault, 2'h0};
      temp_flg <= (flg_clear ? 8'h00 : temp_flg)
                | {ot_cond, otw_cond, 6'h00};                                // RULE20
      comm_flg <= (flg_clear ? 8'h00 : comm_flg) | comm_set;                 // RULE21
    end
  end

  // Summary byte and word
  logic [7:0] sum_byte;
  logic [7:0] sum_high;

  always_comb begin
    sum_high = {|vout_flg, |iout_flg, |in_flg, 1'b0, cond.pgood_n, 3'h0};   // RULE15
    sum_byte[7]   = cond.busy;                                               // RULE14
    sum_byte[6]   = shutdown;
    sum_byte[5]   = vout_flg[7];
    sum_byte[4]   = iout_flg[7];
    sum_byte[3]   = in_flg[4];
    sum_byte[2]   = |temp_flg;
    sum_byte[1]   = |comm_flg;
    sum_byte[0]   = ((|vout_flg) || (|iout_flg) || (|in_flg))
                 && !(|sum_byte[7:1]);
  end

  // Read data answered back over the crossing
  logic [15:0] rd_mux;

  always_comb begin
    case (lnk_hold.code)
      `FLSB_CMD_OUV_ACT:  rd_mux = {8'h00, ouv_act};
      `FLSB_CMD_OC_TRIP:  rd_mux = oc_trip;
      `FLSB_CMD_OC_ACT:   rd_mux = {8'h00, oc_act};
      `FLSB_CMD_OLV_TRIP: rd_mux = olv_trip;
      `FLSB_CMD_OC_WARN:  rd_mux = oc_warn;
      `FLSB_CMD_OT_TRIP:  rd_mux = ot_trip;
      `FLSB_CMD_OT_ACT:   rd_mux = {8'h00, ot_act};
      `FLSB_CMD_OT_WARN:  rd_mux = ot_warn;
      `FLSB_CMD_VOV_TRIP: rd_mux = vov_trip;
      `FLSB_CMD_VOV_ACT:  rd_mux = {8'h00, vov_act};
      `FLSB_CMD_VUV_WARN: rd_mux = vuv_warn;
      `FLSB_CMD_VUV_TRIP: rd_mux = vuv_trip;
      `FLSB_CMD_VUV_ACT:  rd_mux = {8'h00, vuv_act};
      `FLSB_CMD_SUM_BYTE: rd_mux = {8'h00, sum_byte};
      `FLSB_CMD_SUM_WORD: rd_mux = {sum_high, sum_byte};
      `FLSB_CMD_VOUT_FLG: rd_mux = {8'h00, vout_flg};
      `FLSB_CMD_IOUT_FLG: rd_mux = {8'h00, iout_flg};
      `FLSB_CMD_IN_FLG:   rd_mux = {8'h00, in_flg};
      `FLSB_CMD_TEMP_FLG: rd_mux = {8'h00, temp_flg};
      `FLSB_CMD_COMM_FLG: rd_mux = {8'h00, comm_flg};
      default:            rd_mux = 16'hffff;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rsp_data <= 16'h0000;
      ack_tgl  <= 1'b0;
    end else if (req_new) begin
      rsp_data <= rd_mux;
      ack_tgl  <= ~ack_tgl;
    end
  end

endmodule

/* sim/flsb_sva.sv */
`timescale 1ns/1ns
module flsb_sva
  import flsb_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_b,
  input wire flsb_meas_s  meas,
  input wire flsb_cond_s  cond,
  input wire logic        restart,
  input wire logic        shutdown,
  input wire logic        latched_off,
  input wire logic        current_limit,
  input wire logic        lnk_clk,
  input wire logic        lnk_busy,
  input wire logic        lnk_ack,
  input wire logic [15:0] lnk_rdata
);
  AST_LOWLINE_LIMIT: assert property (@(posedge clk) disable iff (!rst_b)
    !cond.high_line |=> current_limit == ($past(meas.iout) >= 16'h001e))
    else $error("low line current limit wrong");
  AST_VIN_OV_TRIP: assert property (@(posedge clk) disable iff (!rst_b)
    meas.vin > 16'h012c |=> shutdown)
    else $error("no shutdown on input overvoltage");
  AST_VIN_UV_TRIP: assert property (@(posedge clk) disable iff (!rst_b)
    meas.vin < 16'h0055 |=> shutdown)
    else $error("no shutdown on input undervoltage");
  AST_LATCH_HOLDS: assert property (@(posedge clk) disable iff (!rst_b)
    latched_off && !restart |=> latched_off)
    else $error("latch dropped without restart");
  AST_LATCH_OFF: assert property (@(posedge clk) disable iff (!rst_b)
    latched_off |-> shutdown)
    else $error("latched but output running");
  AST_ANSWER_BOUND: assert property (@(posedge lnk_clk) disable iff (!rst_b)
    $rose(lnk_busy) |-> ##[1:6] (lnk_ack && !lnk_busy))
    else $error("link answer late");
  AST_ACK_PULSE: assert property (@(posedge lnk_clk) disable iff (!rst_b)
    lnk_ack |=> !lnk_ack)
    else $error("ack longer than one cycle");
  AST_RDATA_HOLD: assert property (@(posedge lnk_clk) disable iff (!rst_b)
    !lnk_ack |-> $stable(lnk_rdata))
    else $error("read data moved without ack");
  cover property (@(posedge clk) $rose(latched_off));
  cover property (@(posedge clk) current_limit && !shutdown);
  cover property (@(posedge lnk_clk) lnk_ack && lnk_rdata == 16'hffff);
endmodule

bind flsb_bank flsb_sva u_flsb_sva (.clk, .rst_b, .meas, .cond, .restart, .shutdown,
  .latched_off, .current_limit, .lnk_clk, .lnk_busy, .lnk_ack, .lnk_rdata);

/* sim/flsb_host.sv */
`timescale 1ns/1ns
module flsb_host (
  input  wire logic        lnk_clk,
  input  wire logic        lnk_busy,
  input  wire logic        lnk_ack,
  input  wire logic [15:0] lnk_rdata,
  output logic             lnk_req,
  output logic             lnk_we,
  output logic [7:0]       lnk_code,
  output logic [15:0]      lnk_wdata,
  output logic             lnk_pec_bad
);
  initial begin
    {lnk_req, lnk_we, lnk_code, lnk_wdata, lnk_pec_bad} = '0;
  end

  // Request is taken only in idle (in wait it marks an overrun), so it drops once busy shows
  // Keep holds it up until the ack edge to probe the overrun path
  task automatic xfer(input logic we, input logic [7:0] c, input logic [15:0] d,
                      input logic bad, input logic keep, output logic [15:0] rd);
    int n;
    n = 0;
    @(posedge lnk_clk);
    #2;
    {lnk_req, lnk_we, lnk_code, lnk_wdata, lnk_pec_bad} = {1'b1, we, c, d, bad};
    while (lnk_busy !== 1'b1 && n < 8) begin
      @(posedge lnk_clk);
      #2;
      n++;
    end
    lnk_req = keep;
    while (lnk_ack !== 1'b1 && n < 16) begin
      @(posedge lnk_clk);
      #2;
      n++;
    end
    rd = (n < 16) ? lnk_rdata : 16'hxxxx;
    // Released lines show a changed pattern, not the stale value
    {lnk_req, lnk_we, lnk_code, lnk_wdata, lnk_pec_bad} = {1'b0, 1'b0, ~c, ~d, 1'b0};
  endtask
endmodule

/* sim/tb_top.sv */
`timescale 1ns/1ns
`include "flsb_consts.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_top;
  import flsb_pkg::*;
  logic        clk, lnk_clk, rst_b, restart, shutdown, latched_off, current_limit;
  logic        lnk_req, lnk_we, lnk_pec_bad, lnk_busy, lnk_ack;
  logic [7:0]  lnk_code;
  logic [15:0] lnk_wdata, lnk_rdata, rv;
  flsb_meas_s  meas;
  flsb_cond_s  cond;
  int          failures = 0;
  int          n_compared = 0;

  flsb_bank u_flsb_bank (.clk, .rst_b, .meas, .cond, .restart, .shutdown, .latched_off,
    .current_limit, .lnk_clk, .lnk_req, .lnk_we, .lnk_code, .lnk_wdata, .lnk_pec_bad,
    .lnk_busy, .lnk_ack, .lnk_rdata);
  flsb_host u_host (.lnk_clk, .lnk_busy, .lnk_ack, .lnk_rdata, .lnk_req, .lnk_we,
    .lnk_code, .lnk_wdata, .lnk_pec_bad);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    lnk_clk = 1'b0;
    #37;
    forever #80 lnk_clk = ~lnk_clk;
  end

  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    u_host.xfer(1'b1, c, d, 1'b0, 1'b0, rv);
  endtask
  task automatic rc(input logic [7:0] c, input logic [15:0] e);
    u_host.xfer(1'b0, c, 16'h0000, 1'b0, 1'b0, rv);
    `CHK(rv, e)
  endtask
  task automatic sm(input logic [15:0] vo, io, vi, te);
    @(negedge clk);
    meas = '{vout: vo, iout: io, vin: vi, temp: te};
    repeat (3) @(negedge clk);
  endtask
  task automatic sc(input logic hl, input logic ii);
    @(negedge clk);
    cond.high_line = hl;
    cond.input_interrupt = ii;
    repeat (3) @(negedge clk);
  endtask
  task automatic rst_pulse;
    @(negedge clk);
    restart = 1'b1;
    @(negedge clk);
    restart = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  task automatic t_regs;
    logic [7:0] a [5] = '{`FLSB_CMD_OUV_ACT, `FLSB_CMD_OC_ACT, `FLSB_CMD_OT_ACT,
                          `FLSB_CMD_VOV_ACT, `FLSB_CMD_VUV_ACT};
    logic [7:0] d [5] = '{8'hc0, 8'hf8, 8'hc0, 8'hc0, 8'hc0};
    logic [7:0] o [5] = '{8'h80, 8'hc0, 8'h80, 8'h80, 8'h80};
    for (int c = 8'h78; c <= 8'h7e; c++) begin
      rc(8'(c), 16'h0000);
    end
    for (int i = 0; i < 5; i++) begin
      rc(a[i], {8'h00, d[i]});
      wr(a[i], 16'h0012);
      rc(a[i], {8'h00, d[i]});
      rc(`FLSB_CMD_COMM_FLG, 16'h0040);
      wr(`FLSB_CMD_CLEAR, 16'h0000);
      wr(a[i], {8'h00, o[i]});
      rc(a[i], {8'h00, o[i]});
      wr(a[i], {8'h00, d[i]});
    end
    rc(`FLSB_CMD_COMM_FLG, 16'h0000);
  endtask

  task automatic t_limits;
    wr(`FLSB_CMD_VOV_TRIP, 16'h012d);
    rc(`FLSB_CMD_VOV_TRIP, 16'h012c);
    wr(`FLSB_CMD_VOV_TRIP, 16'h0100);
    rc(`FLSB_CMD_VOV_TRIP, 16'h0100);
    wr(`FLSB_CMD_VUV_WARN, 16'h0059);
    rc(`FLSB_CMD_VUV_WARN, 16'h005a);
    wr(`FLSB_CMD_VUV_TRIP, 16'h0054);
    rc(`FLSB_CMD_VUV_TRIP, 16'h0055);
    wr(`FLSB_CMD_CLEAR, 16'h0000);
  endtask

  task automatic t_current;
    sc(1'b0, 1'b0);
    sm(16'h0030, 16'h001d, 16'h00e6, 16'h0028);
    `CHK(current_limit, 1'b0)
    rc(`FLSB_CMD_IOUT_FLG, 16'h0000);
    sm(16'h0030, 16'h001e, 16'h00e6, 16'h0028);
    `CHK(current_limit, 1'b1)
    `CHK(shutdown, 1'b0)
    rc(`FLSB_CMD_IOUT_FLG, 16'h00a0);
    sc(1'b1, 1'b0);
    `CHK(current_limit, 1'b0)
    sc(1'b0, 1'b1);
    sm(16'h0020, 16'h001e, 16'h00e6, 16'h0028);
    `CHK(shutdown, 1'b0)
    sc(1'b0, 1'b0);
    `CHK(shutdown, 1'b1)
    rc(`FLSB_CMD_IOUT_FLG, 16'h00e0);
    sm(16'h0030, 16'h0010, 16'h00e6, 16'h0028);
    sc(1'b1, 1'b0);
    rst_pulse;
    `CHK(shutdown, 1'b0)
    rc(`FLSB_CMD_IOUT_FLG, 16'h0000);
  endtask

  task automatic t_temp;
    wr(`FLSB_CMD_OT_ACT, 16'h0080);
    sm(16'h0030, 16'h0010, 16'h00e6, 16'h005b);
    rc(`FLSB_CMD_TEMP_FLG, 16'h0040);
    sm(16'h0030, 16'h0010, 16'h00e6, 16'h0065);
    `CHK(latched_off, 1'b1)
    rc(`FLSB_CMD_TEMP_FLG, 16'h00c0);
    rc(`FLSB_CMD_SUM_BYTE, 16'h0044);
    sm(16'h0030, 16'h0010, 16'h00e6, 16'h0028);
    `CHK(latched_off, 1'b1)
    rc(`FLSB_CMD_TEMP_FLG, 16'h00c0);
    rst_pulse;
    `CHK(shutdown, 1'b0)
    rc(`FLSB_CMD_TEMP_FLG, 16'h0000);
    wr(`FLSB_CMD_OT_ACT, 16'h00c0);
  endtask

  task automatic t_input;
    sm(16'h0030, 16'h0010, 16'h012d, 16'h0028);
    `CHK(shutdown, 1'b1)
    rc(`FLSB_CMD_IN_FLG, 16'h0080);
    rc(`FLSB_CMD_SUM_WORD, 16'h2040);
    sm(16'h0030, 16'h0010, 16'h00e6, 16'h0028);
    `CHK(shutdown, 1'b0)
    sm(16'h0030, 16'h0010, 16'h0054, 16'h0028);
    `CHK(shutdown, 1'b1)
    rc(`FLSB_CMD_IN_FLG, 16'h00b8);
    sm(16'h0030, 16'h0010, 16'h00e6, 16'h0028);
    rst_pulse;
  endtask

  task automatic t_vout;
    wr(`FLSB_CMD_OUV_ACT, 16'h0080);
    @(negedge clk);
    cond.vout_uv_detect = 1'b1;
    cond.vout_ov_warn = 1'b1;
    cond.pgood_n = 1'b1;
    repeat (3) @(negedge clk);
    `CHK(latched_off, 1'b1)
    cond.vout_uv_detect = 1'b0;
    cond.vout_ov_warn = 1'b0;
    rc(`FLSB_CMD_VOUT_FLG, 16'h0050);
    rc(`FLSB_CMD_SUM_WORD, 16'h8840);
    @(negedge clk);
    cond.pgood_n = 1'b0;
    rst_pulse;
    `CHK(latched_off, 1'b0)
    wr(`FLSB_CMD_OUV_ACT, 16'h00c0);
    wr(`FLSB_CMD_OC_ACT, 16'h00c0);
    sc(1'b0, 1'b0);
    sm(16'h0020, 16'h001e, 16'h00e6, 16'h0028);
    `CHK(latched_off, 1'b1)
    sm(16'h0030, 16'h0010, 16'h00e6, 16'h0028);
    `CHK(latched_off, 1'b1)
    sc(1'b1, 1'b0);
    rst_pulse;
    `CHK(shutdown, 1'b0)
    wr(`FLSB_CMD_OC_ACT, 16'h00f8);
  endtask

  task automatic t_comm;
    rc(8'h00, 16'hffff);
    rc(`FLSB_CMD_COMM_FLG, 16'h0080);
    u_host.xfer(1'b1, `FLSB_CMD_OC_WARN, 16'h0010, 1'b1, 1'b0, rv);
    rc(`FLSB_CMD_OC_WARN, 16'h003c);
    rc(`FLSB_CMD_COMM_FLG, 16'h00a0);
    // Request held through busy; reported by the next one, despite the clear
    u_host.xfer(1'b0, `FLSB_CMD_OC_WARN, 16'h0000, 1'b0, 1'b1, rv);
    `CHK(rv, 16'h003c)
    wr(`FLSB_CMD_CLEAR, 16'h0000);
    rc(`FLSB_CMD_COMM_FLG, 16'h0002);
  endtask

  task automatic close_out;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // About 90 link transfers of roughly 1 us each
  initial begin
    #400000;
    failures++;
    close_out;
  end

  initial begin
    rst_b = 1'b0;
    restart = 1'b0;
    meas = '{vout: 16'h0030, iout: 16'h0010, vin: 16'h00e6, temp: 16'h0028};
    cond = '0;
    cond.high_line = 1'b1;
    // Link side needs three of its own edges in reset too
    repeat (12) @(negedge clk);
    repeat (3) @(posedge lnk_clk);
    @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(posedge lnk_clk);
    t_regs;
    t_limits;
    t_current;
    t_temp;
    t_input;
    t_vout;
    t_comm;
    close_out;
  end
endmodule
